//--- free_running_timer_irq_contention_tb.sv
// Self-checking bench for the free-running timer requests and counting
`timescale 1ns/1ps

module free_running_timer_irq_contention_tb;
   import frt_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = SIZE_WORD;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic capture_pin = 1'b0;
   logic ext_clk_pin = 1'b0;
   logic out_a, out_b, capture_irq, match_a_irq, match_b_irq, wrap_irq, irq;
   logic [1:0] irq_vector;
   logic [1:0] top_code;
   logic any_req;
   logic [3:0] lines;
   logic [31:0] v0, v1;
   int failures = 0;
   int checked = 0;

   // ==========================================================
   // Clock, single slave so hready is the slave's own ready
   always #2.5 core_clk = ~core_clk;
   assign hready = hreadyout;
   assign lines = {wrap_irq, match_b_irq, match_a_irq, capture_irq};

   frt_timer dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .capture_pin(capture_pin),
      .ext_clk_pin(ext_clk_pin), .out_a(out_a), .out_b(out_b),
      .capture_irq(capture_irq), .match_a_irq(match_a_irq),
      .match_b_irq(match_b_irq), .wrap_irq(wrap_irq), .irq(irq),
      .irq_vector(irq_vector));

   irq_ctrl_model icm (.core_clk(core_clk), .rst_b(rst_b), .req(lines),
      .top_code(top_code), .any_req(any_req));

   // ==========================================================
   // Reporting
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask

   // ==========================================================
   // AHB-Lite single word transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      n = 0;
      do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50)
      begin
         chk("bus timeout", 32'h0000_0000, 32'h0000_0001);
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h0000_0000, d);
   endtask

   // Bounded wait for one request line; running out is a mismatch
   task automatic wait_line(input int idx, input int lim);
      int n;
      n = 0;
      while (lines[idx] !== 1'b1 && n < lim)
      begin
         @(posedge core_clk);
         n++;
      end
      if (n >= lim)
      begin
         chk("request wait", 32'h0000_0001, 32'h0000_0000);
         final_report();
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd(ADDR_CMP_A, v0);
      chk("cmp a reset", 32'h0000_ffff, v0);
      rd(ADDR_ENABLE, v0);
      chk("enable reset", 32'h0000_0000, v0);
      wr(ADDR_STATUS, 32'h0000_000f);
      rd(ADDR_STATUS, v0);
      chk("status not settable", 32'h0000_0000, v0);
      rd(8'h40, v0);
      chk("unmapped read", 32'h0000_0000, v0);
      // With nothing pending the code rests on the lowest source
      chk("irq idle", 32'h0000_0003, {29'h0, irq, irq_vector});
      chk("okay response", 32'h0000_0000, {31'h0, hresp});
      $display("test reset done");
   endtask

   // Count delta over 64 cycles for each internal divider
   task automatic t_rates;
      for (int c = 0; c < 3; c++)
      begin
         wr(ADDR_CTRL, 32'(c) << CTRL_CKS_LO);
         rd(ADDR_COUNT, v0);
         repeat (61) @(posedge core_clk);
         rd(ADDR_COUNT, v1);
         chk("internal rate", 32'(64 >> (2 * c + 1)), (v1 - v0) & 32'hffff);
      end
      // External source: an extra count at the switch is allowed, so
      // both samples are taken after the change has settled
      wr(ADDR_CTRL, 32'(CKS_EXT) << CTRL_CKS_LO);
      repeat (6) @(posedge core_clk);
      rd(ADDR_COUNT, v0);
      repeat (5)
      begin
         ext_clk_pin <= 1'b1;
         repeat (4) @(posedge core_clk);
         ext_clk_pin <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
      rd(ADDR_COUNT, v1);
      chk("external rate", 32'h0000_0005, (v1 - v0) & 32'hffff);
      $display("test rates done");
   endtask

   task automatic t_match_a;
      wr(ADDR_CMP_A, 32'h0000_0003);
      wr(ADDR_CTRL, 32'h0000_0003);
      // Earlier tests left the count far past the compare value
      wr(ADDR_COUNT, 32'h0000_0000);
      wr(ADDR_ENABLE, 32'h0000_0002);
      wait_line(1, 100);
      @(posedge core_clk);
      chk("out a level", 32'h0000_0001, {31'h0, out_a});
      chk("vector a", 32'h0000_0001, {30'h0, irq_vector});
      // Handler flips the level bit; the next match must follow it
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (10) @(posedge core_clk);
      chk("out a toggled", 32'h0000_0000, {31'h0, out_a});
      rd(ADDR_COUNT, v0);
      chk("cleared count", 32'h0000_0001, {31'h0, v0 <= 32'h3});
      // Park compare A out of reach so the flag is not set again
      wr(ADDR_CMP_A, 32'h0000_ffff);
      wr(ADDR_CLEAR, 32'h0000_0000);
      @(posedge core_clk);
      chk("clear without read", 32'h0000_0001, {31'h0, match_a_irq});
      rd(ADDR_STATUS, v0);
      chk("status a", 32'h0000_0002, v0 & 32'h2);
      wr(ADDR_CLEAR, 32'h0000_000d);
      @(posedge core_clk);
      chk("request drop", 32'h0000_0000, {31'h0, match_a_irq});
      $display("test match a done");
   endtask

   task automatic t_priority;
      wr(ADDR_CTRL, 32'h0000_000c);
      wr(ADDR_CMP_A, 32'h0000_fff8);
      wr(ADDR_CMP_B, 32'h0000_fff4);
      wr(ADDR_COUNT, 32'h0000_fff0);
      wr(ADDR_ENABLE, 32'h0000_000f);
      capture_pin <= 1'b1;
      wait_line(3, 200);
      @(posedge core_clk);
      chk("all lines", 32'h0000_000f, {28'h0, lines});
      chk("out b level", 32'h0000_0001, {31'h0, out_b});
      chk("out a level", 32'h0000_0000, {31'h0, out_a});
      wr(ADDR_ENABLE, 32'h0000_0000);
      @(posedge core_clk);
      chk("masked", 32'h0000_0000, {31'h0, irq});
      wr(ADDR_ENABLE, 32'h0000_000f);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk);
         chk("vector", 32'(i), {30'h0, irq_vector});
         chk("controller rank", 32'(i), {30'h0, top_code});
         chk("controller any", 32'h0000_0001, {31'h0, any_req});
         rd(ADDR_STATUS, v0);
         chk("status left", (32'hf << i) & 32'hf, v0 & 32'hf);
         wr(ADDR_CLEAR, ~(32'h1 << i) & 32'hf);
      end
      @(posedge core_clk);
      chk("all cleared", 32'h0000_0000, {27'h0, irq, lines});
      capture_pin <= 1'b0;
      $display("test priority done");
   endtask

   // External ticks are placed by the bench: the pin rises one cycle
   // before the address phase, so the tick lands in the data phase
   task automatic ext_race(input logic [7:0] a, input logic [31:0] d);
      ext_clk_pin <= 1'b1;
      @(posedge core_clk);
      wr(a, d);
      rd(ADDR_COUNT, v0);
      ext_clk_pin <= 1'b0;
   endtask

   task automatic t_contend;
      wr(ADDR_CTRL, 32'h0000_0031);
      wr(ADDR_CMP_A, 32'h0000_0005);
      wr(ADDR_COUNT, 32'h0000_0005);
      ext_race(ADDR_COUNT, 32'h0000_1234);
      chk("clear beats write", 32'h0000_0000, v0);
      wr(ADDR_CTRL, 32'h0000_0030);
      ext_race(ADDR_COUNT, 32'h0000_00ab);
      chk("write beats tick", 32'h0000_00ab, v0);
      wr(ADDR_COUNT, 32'h0000_fff4);
      ext_race(ADDR_CMP_B, 32'h0000_0100);
      chk("match skipped count", 32'h0000_fff5, v0);
      rd(ADDR_STATUS, v1);
      chk("match b suppressed", 32'h0000_0000, v1 & 32'h4);
      chk("pin b kept", 32'h0000_0001, {31'h0, out_b});
      rd(ADDR_CMP_B, v1);
      chk("compare write lands", 32'h0000_0100, v1);
      $display("test contention done");
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_rates();
      t_match_a();
      t_priority();
      t_contend();
      final_report();
   end
endmodule // free_running_timer_irq_contention_tb

//--- frt_pkg.sv
// Shared constants for the free-running timer and its tick source
package frt_pkg;

   // ==========================================================
   // Register map (byte addresses on the AHB-Lite port)
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CLEAR = 8'h08;
   localparam logic [7:0] ADDR_ENABLE = 8'h0c;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   localparam logic [7:0] ADDR_CMP_A = 8'h14;
   localparam logic [7:0] ADDR_CMP_B = 8'h18;
   localparam logic [7:0] ADDR_CAPTURE = 8'h1c;

   // ==========================================================
   // Control register fields
   localparam int CTRL_W = 6;
   localparam int CTRL_CLR_A = 0;    // clear_on_match_a
   localparam int CTRL_LVL_A = 1;    // out_level_a
   localparam int CTRL_LVL_B = 2;    // out_level_b
   localparam int CTRL_EDGE = 3;     // capture_edge_select, 1 = rising
   localparam int CTRL_CKS_LO = 4;   // clock_select_lo
   localparam int CTRL_CKS_HI = 5;   // clock_select_hi
   localparam logic [5:0] CTRL_RST = 6'h00;

   // ==========================================================
   // Flag, enable and clear fields (same layout in all three)
   localparam int FLG_W = 4;
   localparam int FLG_CAPTURE = 0;
   localparam int FLG_MATCH_A = 1;
   localparam int FLG_MATCH_B = 2;
   localparam int FLG_WRAP = 3;
   localparam logic [3:0] ENABLE_RST = 4'h0;

   // ==========================================================
   // Clock select codes and prescaler taps
   localparam logic [1:0] CKS_DIV2 = 2'h0;
   localparam logic [1:0] CKS_DIV8 = 2'h1;
   localparam logic [1:0] CKS_DIV32 = 2'h2;
   localparam logic [1:0] CKS_EXT = 2'h3;
   localparam int PRE_W = 5;
   localparam int TAP_DIV2 = 0;
   localparam int TAP_DIV8 = 2;
   localparam int TAP_DIV32 = 4;

   // ==========================================================
   // Highest pending request code and bus constants
   localparam logic [1:0] VEC_CAPTURE = 2'h0;
   localparam logic [1:0] VEC_MATCH_A = 2'h1;
   localparam logic [1:0] VEC_MATCH_B = 2'h2;
   localparam logic [1:0] VEC_WRAP = 2'h3;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

//--- frt_timer.sv
// Free-running timer: counter, compares, capture, flags, requests
//
// How it works
// RL1: Four sources; each request is flag and its enable together.
// RL2: Every source has its own request line to the controller.
// RL3: Priority capture, then match A, then match B, then wrap.
// RL4: Counter clear in the write's commit cycle beats the written value.
// RL5: Counter write in the same cycle as an increment wins; tick lost.
// RL6: Compare write in the match cycle completes and suppresses the match.
// RL7: Internal sources increment on the falling edge of the divided clock.
// RL8: Select rewrite from high source to low source counts once.
// RL9: Switching internal to external source may count once as well.
// RL10: Software toggles out level in match handlers for square waves.
// RL11: Request stays high until flag or enable cleared, drops next cycle.
// RL12: Wrap flag set on all-ones to zero; software cannot set it.
// RL13: Flag clears only by reading it as one then writing zero.
// RL14: On match A or B the output pin takes that channel's level bit.
// RL15: With clear-on-match A set, match A returns the counter to zero.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module frt_timer
   import frt_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic capture_pin,
   input wire logic ext_clk_pin,
   output logic out_a,
   output logic out_b,
   output logic capture_irq,
   output logic match_a_irq,
   output logic match_b_irq,
   output logic wrap_irq,
   output logic irq,
   output logic [1:0] irq_vector
);

   // ==========================================================
   // Declarations
   logic addr_ok;
   logic wr_q;
   logic rd_q;
   logic done_q;
   logic rd_latch;
   logic [ADDR_W-1:0] addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   logic wr_ctrl;
   logic wr_clear;
   logic wr_enable;
   logic cnt_wr;
   logic cmp_wr_a;
   logic cmp_wr_b;
   logic [CTRL_W-1:0] ctrl_q;
   logic [FLG_W-1:0] enable_q;
   logic [FLG_W-1:0] flag_q;
   logic [FLG_W-1:0] flag_d;
   logic [FLG_W-1:0] armed_q;
   logic [FLG_W-1:0] armed_d;
   logic [FLG_W-1:0] event_vec;
   logic [FLG_W-1:0] clr_vec;
   logic [FLG_W-1:0] irq_line;
   logic [CNT_W-1:0] counter_q;
   logic [CNT_W-1:0] cmp_a_q;
   logic [CNT_W-1:0] cmp_b_q;
   logic [CNT_W-1:0] capture_q;
   logic tick;
   logic match_a;
   logic match_b;
   logic clear_a;
   logic wrap_ev;
   logic cap_meta_q;
   logic cap_sync_q;
   logic cap_prev_q;
   logic cap_ev;
   logic out_a_q;
   logic out_b_q;

   // ==========================================================
   // Increment source
   tick_source #(
      .PW(PRE_W)
   ) u_tick (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clk_sel(ctrl_q[CTRL_CKS_HI:CTRL_CKS_LO]),
      .ext_clk_pin(ext_clk_pin),
      .tick(tick)
   );

   // ==========================================================
   // AHB-Lite slave: writes take no wait, reads take one wait state
   // The wait lets a write just ahead of a read land before sampling
   assign addr_ok = hsel & htrans[1] & hready & (hsize == SIZE_WORD);
   assign rd_latch = rd_q & ~done_q;
   assign hreadyout = ~rd_latch;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_q;

   // Address phase capture
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= '0;
      end
      else if (hready)
      begin
         wr_q <= addr_ok & hwrite;
         rd_q <= addr_ok & ~hwrite;
         addr_q <= haddr[ADDR_W-1:0];
      end
   end

   // Read data is sampled in the wait cycle
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         done_q <= 1'b0;
         hrdata_q <= RDATA_RST;
      end
      else
      begin
         done_q <= rd_latch;
         if (rd_latch)
            hrdata_q <= rd_mux;
      end
   end

   // Read map; write-only and unmapped words read as zero
   always_comb
   begin
      rd_mux = '0;
      case (addr_q)
         ADDR_CTRL: rd_mux = 32'(ctrl_q);
         ADDR_STATUS: rd_mux = 32'(flag_q);
         ADDR_ENABLE: rd_mux = 32'(enable_q);
         ADDR_COUNT: rd_mux = 32'(counter_q);
         ADDR_CMP_A: rd_mux = 32'(cmp_a_q);
         ADDR_CMP_B: rd_mux = 32'(cmp_b_q);
         ADDR_CAPTURE: rd_mux = 32'(capture_q);
         default: rd_mux = '0;
      endcase
   end

   // Write strobes in the data phase
   assign wr_ctrl = wr_q & (addr_q == ADDR_CTRL);
   assign wr_clear = wr_q & (addr_q == ADDR_CLEAR);
   assign wr_enable = wr_q & (addr_q == ADDR_ENABLE);
   assign cnt_wr = wr_q & (addr_q == ADDR_COUNT);
   assign cmp_wr_a = wr_q & (addr_q == ADDR_CMP_A);
   assign cmp_wr_b = wr_q & (addr_q == ADDR_CMP_B);

   // ==========================================================
   // Software control registers
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         ctrl_q <= CTRL_RST;
         enable_q <= ENABLE_RST;
         cmp_a_q <= '1;
         cmp_b_q <= '1;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= hwdata[CTRL_W-1:0];
         if (wr_enable)
            enable_q <= hwdata[FLG_W-1:0];
         if (cmp_wr_a)
            cmp_a_q <= hwdata[CNT_W-1:0];
         if (cmp_wr_b)
            cmp_b_q <= hwdata[CNT_W-1:0];
      end
   end

   // ==========================================================
   // Compare and counter
   // A match fires on the tick that would move the count past the value,
   // so clear-on-match gives a period of compare value plus one
   assign match_a = tick & (counter_q == cmp_a_q) & ~cmp_wr_a; // RL6
   assign match_b = tick & (counter_q == cmp_b_q) & ~cmp_wr_b; // RL6
   assign clear_a = match_a & ctrl_q[CTRL_CLR_A]; // RL15
   assign wrap_ev = tick & (counter_q == '1) & ~clear_a & ~cnt_wr; // RL12

   // Clear beats a write, a write beats an increment
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         counter_q <= '0;
      else if (clear_a)
         counter_q <= '0; // RL4 RL15
      else if (cnt_wr)
         counter_q <= hwdata[CNT_W-1:0]; // RL5
      else if (tick)
         counter_q <= counter_q + CNT_W'(1);
   end

   // Output pins follow the level bits on a match
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
      end
      else
      begin
         if (match_a)
            out_a_q <= ctrl_q[CTRL_LVL_A]; // RL14
         if (match_b)
            out_b_q <= ctrl_q[CTRL_LVL_B]; // RL14
      end
   end
   assign out_a = out_a_q;
   assign out_b = out_b_q;

   // ==========================================================
   // Input capture: the pin is synchronised before the edge detector
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         cap_meta_q <= 1'b0;
         cap_sync_q <= 1'b0;
         cap_prev_q <= 1'b0;
         capture_q <= '0;
      end
      else
      begin
         cap_meta_q <= capture_pin;
         cap_sync_q <= cap_meta_q;
         cap_prev_q <= cap_sync_q;
         if (cap_ev)
            capture_q <= counter_q;
      end
   end
   assign cap_ev = ctrl_q[CTRL_EDGE] ? (cap_sync_q & ~cap_prev_q)
                                     : (~cap_sync_q & cap_prev_q);

   // ==========================================================
   // Flags: hardware sets, read-one then write-zero clears
   assign event_vec = {wrap_ev, match_b, match_a, cap_ev}; // RL1

   for (genvar i = 0; i < FLG_W; i++)
   begin : g_flag
      // Writing one is ignored; an unread flag cannot be cleared
      assign clr_vec[i] = wr_clear & ~hwdata[i] & armed_q[i]; // RL13
      // A new event in the clearing cycle keeps the flag set
      assign flag_d[i] = event_vec[i] | (flag_q[i] & ~clr_vec[i]);
      assign armed_d[i] = (rd_latch && addr_q == ADDR_STATUS) ?
                          flag_q[i] : (armed_q[i] & ~clr_vec[i]);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         flag_q <= '0;
         armed_q <= '0;
      end
      else
      begin
         flag_q <= flag_d; // RL12 RL13
         armed_q <= armed_d;
      end
   end

   // ==========================================================
   // Requests: one level per source, plus summary and top source
   assign irq_line = flag_q & enable_q; // RL1 RL11
   assign capture_irq = irq_line[FLG_CAPTURE]; // RL2
   assign match_a_irq = irq_line[FLG_MATCH_A]; // RL2
   assign match_b_irq = irq_line[FLG_MATCH_B]; // RL2
   assign wrap_irq = irq_line[FLG_WRAP]; // RL2
   assign irq = |irq_line;

   // Code of the highest pending source; meaningful while irq is high
   always_comb
   begin
      if (irq_line[FLG_CAPTURE])
         irq_vector = VEC_CAPTURE; // RL3
      else if (irq_line[FLG_MATCH_A])
         irq_vector = VEC_MATCH_A;
      else if (irq_line[FLG_MATCH_B])
         irq_vector = VEC_MATCH_B;
      else
         irq_vector = VEC_WRAP;
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_irq_follows;
      (match_a && enable_q[FLG_MATCH_A]) |=> match_a_irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) // RL1
      else $error("enabled match A raised no request");

   property p_lines_apart;
      (match_b_irq && !flag_q[FLG_MATCH_A]) |-> !match_a_irq;
   endproperty
   a_lines_apart: assert property (p_lines_apart) // RL2
      else $error("match A line follows another source");

   property p_prio;
      (!capture_irq && match_a_irq) |-> irq_vector == VEC_MATCH_A;
   endproperty
   a_prio: assert property (p_prio) // RL3
      else $error("wrong highest source code");

   property p_clear_wins;
      (clear_a && cnt_wr) |=> counter_q == '0;
   endproperty
   a_clear_wins: assert property (p_clear_wins) // RL4
      else $error("counter write beat the clear");

   property p_write_wins;
      (cnt_wr && tick && !clear_a) |=>
         counter_q == $past(hwdata[CNT_W-1:0]);
   endproperty
   a_write_wins: assert property (p_write_wins) // RL5
      else $error("increment disturbed a counter write");

   property p_match_inhibit;
      (tick && counter_q == cmp_b_q && cmp_wr_b && !flag_q[FLG_MATCH_B])
         |=> !flag_q[FLG_MATCH_B];
   endproperty
   a_match_inhibit: assert property (p_match_inhibit) // RL6
      else $error("match B set during compare write");

   property p_drop;
      (clr_vec[FLG_MATCH_A] && !match_a) |=> !match_a_irq;
   endproperty
   a_drop: assert property (p_drop) // RL11
      else $error("request did not drop after clear");

   property p_wrap;
      (tick && counter_q == '1 && !clear_a && !cnt_wr) |=>
         flag_q[FLG_WRAP] && counter_q == '0;
   endproperty
   a_wrap: assert property (p_wrap) // RL12
      else $error("wrap not flagged");

   property p_write_one;
      (wr_clear && hwdata[FLG_WRAP] && flag_q[FLG_WRAP]) |=>
         flag_q[FLG_WRAP];
   endproperty
   a_write_one: assert property (p_write_one) // RL13
      else $error("writing one cleared a flag");

   property p_pin_level;
      match_b |=> out_b == $past(ctrl_q[CTRL_LVL_B]);
   endproperty
   a_pin_level: assert property (p_pin_level) // RL14
      else $error("pin B missed its level");

   property p_clear_on_a;
      (match_a && ctrl_q[CTRL_CLR_A]) |=> counter_q == '0;
   endproperty
   a_clear_on_a: assert property (p_clear_on_a) // RL15
      else $error("counter not cleared on match A");

   c_clear_a: cover property (clear_a);
   c_wrap: cover property (wrap_ev && enable_q[FLG_WRAP]);
   c_capture: cover property (cap_ev);
   c_race: cover property (tick && cnt_wr);

endmodule // frt_timer

//--- irq_ctrl_model.sv
// Interrupt controller model that ranks the four timer request lines
`timescale 1ns/1ps

module irq_ctrl_model
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [3:0] req,
   output logic [1:0] top_code,
   output logic any_req
);
   // ==========================================================
   // Priority encoder, lowest line number wins
   // Each line is its own input, so no source can hide another
   always_comb
   begin
      any_req = |req;
      top_code = 2'h3;
      for (int i = 3; i >= 0; i--)
      begin
         if (req[i] === 1'b1)
         begin
            top_code = 2'(i);
         end
      end
   end
endmodule // irq_ctrl_model

//--- tick_source.sv
// Clock source selection and increment pulse generation
`timescale 1ns/1ps

module tick_source
   import frt_pkg::*;
#(
   parameter int PW = PRE_W
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [1:0] clk_sel,
   input wire logic ext_clk_pin,
   output logic tick
);

   logic [PW-1:0] pre_q;
   logic ext_meta_q;
   logic ext_sync_q;
   logic level_q;
   logic src_level;

   // ==========================================================
   // Prescaler and external clock synchroniser
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         pre_q <= '0;
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_q + PW'(1);
         ext_meta_q <= ext_clk_pin;
         ext_sync_q <= ext_meta_q;
      end
   end

   // External source is inverted so its rising edge looks like a fall
   always_comb
   begin
      unique case (clk_sel)
         CKS_DIV2: src_level = pre_q[TAP_DIV2];
         CKS_DIV8: src_level = pre_q[TAP_DIV8];
         CKS_DIV32: src_level = pre_q[TAP_DIV32];
         CKS_EXT: src_level = ~ext_sync_q;
      endcase
   end

   // Level of whichever source was selected last cycle
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         level_q <= 1'b0;
      else
         level_q <= src_level;
   end

   // A select rewrite from high to low is a fall as well, so it counts
   assign tick = level_q & ~src_level; // RL7 RL8 RL9

   // ==========================================================
   // Assertions
   property p_switch_fall;
      @(posedge core_clk) disable iff (!rst_b)
      ($changed(clk_sel) && $past(src_level) && !src_level) |-> tick;
   endproperty
   a_switch_fall: assert property (p_switch_fall) // RL8
      else $error("select change high to low gave no increment");

   cover property (@(posedge core_clk) disable iff (!rst_b)
      $changed(clk_sel) && tick);

endmodule // tick_source
